/* design/cfg_status_pkg.sv */
// types shared by the status and override block
// assumes cfg_status_regs.svh is on the include path
`default_nettype none
`include "cfg_status_regs.svh"

package cfg_status_pkg;

	// whole state of the block, registered in one always_ff
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [3:0] waddr;
		logic [31:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [`CTRL_W-1:0] ctrl;
		logic [`EV_W-1:0] event_flags;
		logic [`EV_W-1:0] mask;
		logic irq;
		logic cfg_active_d;
		logic read_strobe_n_d;
		logic top_pin_out;
		logic top_pin_oe_n;
		logic init_done_out;
		logic init_done_oe_n;
		logic [`USER_IO_W-1:0] user_io_oe_n;
		logic user_reg_clear_n;
	} state_t;

endpackage : cfg_status_pkg

`default_nettype wire

/* design/cfg_status_regs.svh */
// offsets, field positions, reset values and widths of the status and override block
// assumes a 32-bit AXI4-Lite register bus, one register per aligned word
`ifndef CFG_STATUS_REGS_SVH
`define CFG_STATUS_REGS_SVH

// ***************************************************
// register byte offsets
// ***************************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_EVENT 4'h8
`define REG_MASK 4'hc

// ***************************************************
// control fields (option enables)
// ***************************************************
`define CTRL_INIT_DONE_EN 0
`define CTRL_OE_OVR_EN 1
`define CTRL_CLR_OVR_EN 2
`define CTRL_PARALLEL_ASYNC_EN 3
`define CTRL_W 4

// ***************************************************
// live status fields
// ***************************************************
`define STAT_CFG_ACTIVE 0
`define STAT_READY 1
`define STAT_OE_PIN 2
`define STAT_CLR_PIN_N 3
`define STAT_W 4

// ***************************************************
// sticky event fields
// ***************************************************
`define EV_CFG_START 0
`define EV_INIT_DONE 1
`define EV_READ_STROBE 2
`define EV_CLR_APPLIED 3
`define EV_W 4

// ***************************************************
// widths and reset values
// ***************************************************
`define USER_IO_W 8
`define RST_CTRL 4'h0
`define RST_MASK 4'h0
`define RST_RELEASED 1'b1
`define RST_IO_OE_N 8'hff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* design/config_status_global_override.sv */
// status pins and global overrides of a programmable logic device, with AXI4-Lite registers
// assumes all pin inputs are synchronous to aclk; two-way pins are split into out and oe_n
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`default_nettype none
`include "cfg_status_regs.svh"

module config_status_global_override (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// from the configuration core
	input wire logic cfg_active,
	input wire logic byte_accept_ready,
	// pins
	input wire logic read_strobe_n,
	input wire logic global_output_enable_override,
	input wire logic global_clear_override_n,
	output logic top_parallel_data_pin_out,
	output logic top_parallel_data_pin_oe_n,
	output logic init_done_out,
	output logic init_done_oe_n,
	// loaded design's own use of the shared pins
	input wire logic user_top_pin_out,
	input wire logic user_top_pin_oe_n,
	input wire logic user_init_pin_out,
	input wire logic user_init_pin_oe_n,
	input wire logic [`USER_IO_W-1:0] user_io_oe_n_in,
	input wire logic user_reg_clear_n_in,
	// gated results toward the I/O ring and the registers
	output logic [`USER_IO_W-1:0] user_io_oe_n,
	output logic user_reg_clear_n,
	output logic irq
);

	// ***************************************************
	// state
	// ***************************************************
	cfg_status_pkg::state_t st_ff; // current state
	cfg_status_pkg::state_t nxt_st; // next state

	// ***************************************************
	// next-state logic
	// ***************************************************
	// one combinational pass computes bus, events and pins
	always_comb begin
		logic aw_take;
		logic w_take;
		logic [`EV_W-1:0] ev_set;
		logic [`STAT_W-1:0] live;
		logic strobe_req;
		logic oe_ovr;
		logic clr_ovr;
		logic rd_event;
		nxt_st = st_ff;
		aw_take = awvalid && st_ff.awready;
		w_take = wvalid && st_ff.wready;
		ev_set = '0;
		live = '0;
		rd_event = 1'b0;

		// overrides are honoured only with their option on
		// option gating
		oe_ovr = st_ff.ctrl[`CTRL_OE_OVR_EN] && !global_output_enable_override;
		clr_ovr = st_ff.ctrl[`CTRL_CLR_OVR_EN] && !global_clear_override_n;
		strobe_req = st_ff.ctrl[`CTRL_PARALLEL_ASYNC_EN] && !read_strobe_n;

		// live pin and core levels for the status register
		live[`STAT_CFG_ACTIVE] = cfg_active;
		live[`STAT_READY] = byte_accept_ready;
		live[`STAT_OE_PIN] = global_output_enable_override;
		live[`STAT_CLR_PIN_N] = global_clear_override_n;

		// event sources, edges seen against last cycle except clear, a level
		ev_set[`EV_CFG_START] = cfg_active && !st_ff.cfg_active_d;
		ev_set[`EV_INIT_DONE] = !cfg_active && st_ff.cfg_active_d;
		ev_set[`EV_READ_STROBE] = strobe_req && st_ff.read_strobe_n_d;
		ev_set[`EV_CLR_APPLIED] = clr_ovr;
		nxt_st.cfg_active_d = cfg_active;
		nxt_st.read_strobe_n_d = read_strobe_n;

		// write channel: address and data taken in either order
		if (aw_take) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.waddr = awaddr;
		end
		if (w_take) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = wdata;
			nxt_st.wstrb0 = wstrb[0];
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			// both halves present: commit and answer
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = `RESP_OKAY;
			if (st_ff.waddr == `REG_CTRL) begin
				if (st_ff.wstrb0) begin
					nxt_st.ctrl = st_ff.wdata[`CTRL_W-1:0];
				end
			end else if (st_ff.waddr == `REG_MASK) begin
				if (st_ff.wstrb0) begin
					nxt_st.mask = st_ff.wdata[`EV_W-1:0];
				end
			end else if (st_ff.waddr == `REG_STATUS || st_ff.waddr == `REG_EVENT) begin
				// read-only registers ignore writes
				nxt_st.bresp = `RESP_OKAY;
			end else begin
				// unmapped offset
				nxt_st.bresp = `RESP_SLVERR;
			end
		end else if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// ready again only when nothing of that kind is held
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

		// read channel: one read at a time, answer next cycle
		if (arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = `RESP_OKAY;
			nxt_st.rdata = '0;
			if (araddr == `REG_CTRL) begin
				nxt_st.rdata[`CTRL_W-1:0] = st_ff.ctrl;
			end else if (araddr == `REG_STATUS) begin
				nxt_st.rdata[`STAT_W-1:0] = live;
			end else if (araddr == `REG_EVENT) begin
				nxt_st.rdata[`EV_W-1:0] = st_ff.event_flags;
				rd_event = 1'b1;
			end else if (araddr == `REG_MASK) begin
				nxt_st.rdata[`EV_W-1:0] = st_ff.mask;
			end else begin
				nxt_st.rresp = `RESP_SLVERR;
			end
		end else if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// sticky events: read clears, a new event in that cycle survives
		nxt_st.event_flags = (rd_event ? '0 : st_ff.event_flags) | ev_set;
		nxt_st.irq = |(nxt_st.event_flags & st_ff.mask);

		// top data pin: readiness while the strobe is held low
		// strobe drives pin
		if (strobe_req) begin
			nxt_st.top_pin_oe_n = 1'b0;
			nxt_st.top_pin_out = byte_accept_ready;
		end else if (st_ff.ctrl[`CTRL_PARALLEL_ASYNC_EN] && cfg_active) begin
			// configuration owns the pin as an input; keep it released
			nxt_st.top_pin_oe_n = 1'b1;
			nxt_st.top_pin_out = 1'b0;
		end else begin
			nxt_st.top_pin_oe_n = user_top_pin_oe_n;
			nxt_st.top_pin_out = user_top_pin_out;
		end

		// open-drain init-done: pull low only while configuring
		if (st_ff.ctrl[`CTRL_INIT_DONE_EN]) begin
			nxt_st.init_done_out = 1'b0;
			if (cfg_active) begin
				nxt_st.init_done_oe_n = 1'b0;
			end else begin
				nxt_st.init_done_oe_n = 1'b1;
			end
		end else begin
			// option off: ordinary user pin
			nxt_st.init_done_out = user_init_pin_out;
			nxt_st.init_done_oe_n = user_init_pin_oe_n;
		end

		// global output-enable override
		// tristate every I/O
		nxt_st.user_io_oe_n = oe_ovr ? {`USER_IO_W{1'b1}} : user_io_oe_n_in;

		// global clear override
		// clear every register
		nxt_st.user_reg_clear_n = clr_ovr ? 1'b0 : user_reg_clear_n_in;
	end

	// ***************************************************
	// state register
	// ***************************************************
	// synchronous reset: pins released, options off, bus idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.ctrl <= `RST_CTRL;
			st_ff.mask <= `RST_MASK;
			st_ff.arready <= 1'b1;
			st_ff.read_strobe_n_d <= `RST_RELEASED;
			st_ff.top_pin_oe_n <= `RST_RELEASED;
			st_ff.init_done_oe_n <= `RST_RELEASED;
			st_ff.user_io_oe_n <= `RST_IO_OE_N;
			st_ff.user_reg_clear_n <= `RST_RELEASED;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ***************************************************
	// outputs, each straight from the state register
	// ***************************************************
	assign awready = st_ff.awready;
	assign wready = st_ff.wready;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = st_ff.arready;
	assign rvalid = st_ff.rvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign top_parallel_data_pin_out = st_ff.top_pin_out;
	assign top_parallel_data_pin_oe_n = st_ff.top_pin_oe_n;
	assign init_done_out = st_ff.init_done_out;
	assign init_done_oe_n = st_ff.init_done_oe_n;
	assign user_io_oe_n = st_ff.user_io_oe_n;
	assign user_reg_clear_n = st_ff.user_reg_clear_n;
	assign irq = st_ff.irq;

endmodule // config_status_global_override

`default_nettype wire

/* verification/cfg_status_chk.sv */
// checker of the pin gating and write answers of the status block
// assumes it is bound to the top module and sees its ports only
`default_nettype none
`include "cfg_status_regs.svh"

module cfg_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic cfg_active,
	input wire logic byte_accept_ready,
	input wire logic read_strobe_n,
	input wire logic global_output_enable_override,
	input wire logic global_clear_override_n,
	input wire logic top_parallel_data_pin_out,
	input wire logic top_parallel_data_pin_oe_n,
	input wire logic init_done_oe_n,
	input wire logic user_init_pin_oe_n,
	input wire logic [7:0] user_io_oe_n_in,
	input wire logic [7:0] user_io_oe_n
);
	logic [3:0] a_ff, d_ff, c_ff; // address and data of the last write, shadow of the option enables
	logic b_ff, s_ff; // response edge and low byte-lane enable of the last write
	// shadow lags one cycle, so no claim but a_init_user is made while the response is pending
	wire ok = !bvalid;
	// shadow follows writes of the control word
	always_ff @(posedge aclk) begin
		b_ff <= bvalid;
		if (awvalid && awready) a_ff <= awaddr;
		if (wvalid && wready) d_ff <= wdata[3:0];
		// a write with the low byte lane off leaves the control word alone
		if (wvalid && wready) s_ff <= wstrb[0];
		if (!aresetn) c_ff <= 4'h0;
		else if (bvalid && !b_ff && a_ff == `REG_CTRL && s_ff) c_ff <= d_ff;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence w_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence w_answer;
		!awready ##1 bvalid;
	endsequence
	a_write_answer: assert property (w_take |=> w_answer) else $error("write not answered");
	a_init_low: assert property (ok && c_ff[0] && cfg_active |=> !init_done_oe_n)
		else $error("init done not pulled low");
	a_init_release: assert property (ok && c_ff[0] && !cfg_active |=> init_done_oe_n)
		else $error("init done not released");
	a_ready_drive: assert property (ok && c_ff[3] && !read_strobe_n |=>
		!top_parallel_data_pin_oe_n && top_parallel_data_pin_out == $past(byte_accept_ready))
		else $error("readiness not on top pin");
	a_io_tristate: assert property (ok && c_ff[1] && !global_output_enable_override |=> &user_io_oe_n)
		else $error("user io not tristated");
	a_io_follow: assert property (ok && (!c_ff[1] || global_output_enable_override) |=>
		user_io_oe_n == $past(user_io_oe_n_in)) else $error("user io enables not passed");
	a_init_user: assert property (!c_ff[0] |=> init_done_oe_n == $past(user_init_pin_oe_n))
		else $error("init pin not passed");
	a_strobe_idle: assert property (ok && c_ff[3] && !cfg_active && read_strobe_n |=>
		top_parallel_data_pin_oe_n) else $error("top pin driven without strobe");
endmodule // cfg_chk

bind config_status_global_override cfg_chk chk_u (.*);
`default_nettype wire

/* verification/host_model.sv */
// host and monitor on the far side of the status pins
// assumes the bench asks for polling through poll
`default_nettype none

module host_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic poll,
	input wire logic init_done_out,
	input wire logic init_done_oe_n,
	input wire logic top_parallel_data_pin_out,
	input wire logic top_parallel_data_pin_oe_n,
	output logic read_strobe_n,
	output logic [7:0] rise_cnt,
	output logic top_seen
);
	logic init_wire, last_ff, init_d_ff;
	assign read_strobe_n = !poll;
	// pull-up wins while the pin is released
	assign init_wire = init_done_oe_n ? 1'b1 : init_done_out;
	// released data line shows the inverse of its last driven value
	assign top_seen = top_parallel_data_pin_oe_n ? !last_ff : top_parallel_data_pin_out;
	// no test-port pins are ever toggled by this host
	always_ff @(posedge aclk) begin
		if (!top_parallel_data_pin_oe_n) last_ff <= top_parallel_data_pin_out;
		init_d_ff <= init_wire;
		// count rising edges, the level alone is high already
		if (!aresetn) rise_cnt <= 8'h00;
		else if (init_wire && !init_d_ff) rise_cnt <= rise_cnt + 8'h01;
	end
endmodule // host_model
`default_nettype wire

/* verification/testbench.sv */
// bench: register access, init-done, polling and override tests
// assumes the checker is bound through its own file
`default_nettype none
`include "cfg_status_regs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic cfg_active = 1'b0, byte_accept_ready = 1'b0, poll = 1'b0, user_reg_clear_n_in = 1'b1;
	logic global_output_enable_override = 1'b1, global_clear_override_n = 1'b1, read_strobe_n;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic [31:0] wdata = 32'h0, rdata, rd_v;
	logic [1:0] bresp, rresp;
	logic [7:0] user_io_oe_n_in = 8'h5a, user_io_oe_n, rise_cnt;
	logic awready, wready, bvalid, arready, rvalid, irq, top_seen, user_reg_clear_n;
	logic top_parallel_data_pin_out, top_parallel_data_pin_oe_n, init_done_out, init_done_oe_n;
	int error_cnt = 0;
	int tests_run = 0;
	config_status_global_override dut_u (.*, .user_top_pin_out(1'b0), .user_top_pin_oe_n(1'b1),
		.user_init_pin_out(1'b0), .user_init_pin_oe_n(1'b1));
	host_model host_u (.*);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// each half is released on the edge that takes it; unaligned offsets are unmapped
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (i == 40) error_cnt++;
		if (i == 40) results();
		chk("bresp", bresp, (a[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY);
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] e, input string n);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd_v = rdata;
		rready <= 1'b0;
		if (i == 40) error_cnt++;
		if (i == 40) results();
		chk(n, rd_v, e);
		chk("rresp", rresp, (a[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY);
	endtask
	initial begin
		tick(16);
		aresetn <= 1'b1;
		// reset values, unmapped place, masked byte lane
		rdc(`REG_CTRL, 32'h0, "ctrl reset");
		rdc(`REG_MASK, 32'h0, "mask reset");
		rdc(4'h2, 32'h0, "unmapped read");
		wr(4'h2, 32'hf, 4'hf);
		wr(`REG_CTRL, 32'hf, 4'he);
		rdc(`REG_CTRL, 32'h0, "strobe off");
		$display("test registers done");
		// init-done pin and interrupt
		wr(`REG_MASK, 32'h1, 4'hf);
		wr(`REG_CTRL, 32'h1, 4'hf);
		rdc(`REG_EVENT, 32'h0, "event idle");
		chk("init before", init_done_oe_n, 1'b1);
		cfg_active <= 1'b1;
		tick(3);
		chk("init low", init_done_oe_n, 1'b0);
		chk("irq set", irq, 1'b1);
		rdc(`REG_EVENT, 32'h1, "event start");
		tick(2);
		chk("irq clear", irq, 1'b0);
		cfg_active <= 1'b0;
		tick(3);
		chk("init rise", rise_cnt, 8'h01);
		chk("irq masked", irq, 1'b0);
		rdc(`REG_EVENT, 32'h2, "event done");
		$display("test init done");
		// polling readiness on the top data pin
		wr(`REG_CTRL, 32'h8, 4'hf);
		poll <= 1'b1;
		tick(3);
		chk("busy", top_seen, 1'b0);
		byte_accept_ready <= 1'b1;
		tick(3);
		chk("ready", top_seen, 1'b1);
		chk("ready driven", top_parallel_data_pin_oe_n, 1'b0);
		rdc(`REG_STATUS, 32'he, "status live");
		poll <= 1'b0;
		tick(3);
		chk("released", top_parallel_data_pin_oe_n, 1'b1);
		rdc(`REG_EVENT, 32'h4, "strobe event");
		$display("test polling done");
		// global overrides, then ignored with options off
		wr(`REG_CTRL, 32'h6, 4'hf);
		global_output_enable_override <= 1'b0;
		global_clear_override_n <= 1'b0;
		tick(3);
		chk("io tristate", user_io_oe_n, 8'hff);
		chk("reg clear", user_reg_clear_n, 1'b0);
		global_output_enable_override <= 1'b1;
		global_clear_override_n <= 1'b1;
		user_io_oe_n_in <= 8'h3c;
		tick(3);
		chk("io follow", user_io_oe_n, 8'h3c);
		chk("clear follow", user_reg_clear_n, 1'b1);
		rdc(`REG_EVENT, 32'h8, "clear event");
		wr(`REG_CTRL, 32'h0, 4'hf);
		global_output_enable_override <= 1'b0;
		global_clear_override_n <= 1'b0;
		tick(3);
		chk("oe ignored", user_io_oe_n, 8'h3c);
		chk("clear ignored", user_reg_clear_n, 1'b1);
		$display("test overrides done");
		results();
	end
endmodule // testbench
`default_nettype wire
